// *** mmd_pkg.sv ***
package mmd_pkg;
  localparam int unsigned ADDR_W       = 20;
  localparam logic [19:0] ROM_TOP      = 20'h0ffff;
  localparam logic [19:0] VEC_BASE     = 20'h0ffdc;
  localparam logic [19:0] FLASH_BASE   = 20'h03000;
  localparam logic [19:0] FLASH_TOP    = 20'h03fff;
  localparam logic [19:0] RAM_BASE     = 20'h00400;
  localparam logic [19:0] SFR0_BASE    = 20'h00000;
  localparam logic [19:0] SFR0_TOP     = 20'h002ff;
  localparam logic [19:0] SFR1_BASE    = 20'h02c00;
  localparam logic [19:0] SFR1_TOP     = 20'h02fff;
  localparam int unsigned ROM_KB_DEF   = 32;
  localparam int unsigned RAM_HALFKB_DEF = 5;
  localparam int unsigned FLASH_BLK_LSB = 10;
  localparam logic [7:0]  OPEN_READ    = 8'hff;
  localparam logic [7:0]  RESET_DATA   = 8'h00;

  typedef enum logic [6:0]
  {
    MMD_NONE  = 7'h01,
    MMD_SFR   = 7'h02,
    MMD_RAM   = 7'h04,
    MMD_FLASH = 7'h08,
    MMD_ROM   = 7'h10,
    MMD_VEC   = 7'h20,
    MMD_RSVD  = 7'h40
  } mmd_region_t;

  typedef struct packed
  {
    logic        req;
    logic        wr;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } mmd_req_t;

  typedef struct packed
  {
    logic        sfr;
    logic        ram;
    logic        flash;
    logic [3:0]  flash_blk;
    logic        rom;
    logic        vec;
    logic        wr;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } mmd_sel_t;
endpackage

// *** mmd_decoder.sv ***
// Behaviour
// R1: Every address of the 1-Mbyte space from zero goes to exactly one region or to reserved space.
// R2: Program ROM grows down from 0FFFFh, so 32 Kbytes start at 08000h.
// R3: 0FFDCh to 0FFFFh is the fixed vector table holding handler start addresses.
// R4: Data flash decodes at 03000h to 03FFFh whatever the ROM size.
// R5: Data flash is split into four 1-Kbyte blocks A to D, each selected on its own.
// R6: Internal RAM grows up from 00400h, so 2.5 Kbytes end at 00DFFh.
// R7: Internal RAM serves both data and the stack for calls and interrupts.
// R8: Peripheral registers decode at 00000h to 002FFh and 02C00h to 02FFFh.
// R9: Unallocated register locations are reserved, need no storage and must not be used.
// R10: An address in no region selects nothing, ignores writes and reads a fixed value.
`timescale 1ns/100ps
module mmd_decoder #(
  parameter int unsigned ROM_KB     = mmd_pkg::ROM_KB_DEF,
  parameter int unsigned RAM_HALFKB = mmd_pkg::RAM_HALFKB_DEF
)(
  input  wire logic              core_clk,   // Core clock
  input  wire logic              reset_n,    // Async reset
  input  wire mmd_pkg::mmd_req_t req_in,     // Access from core
  input  wire logic [7:0]        rdata_sfr,  // Read data, registers
  input  wire logic [7:0]        rdata_ram,  // Read data, RAM
  input  wire logic [7:0]        rdata_flash,// Read data, data flash
  input  wire logic [7:0]        rdata_rom,  // Read data, ROM and vectors
  output mmd_pkg::mmd_sel_t      sel_out,    // Registered region selects
  output mmd_pkg::mmd_region_t   region,     // Decoded region of last access
  output logic [7:0]             rdata       // Read data to core
);
  // ROM must sit above data flash; RAM must end below 02C00h, so at most 20 half-Kbytes
  if (ROM_KB < 1 || ROM_KB > 48)
  begin : g_rom_size_check
    $error("ROM size out of range");
  end
  if (RAM_HALFKB < 1 || RAM_HALFKB > 20)
  begin : g_ram_size_check
    $error("RAM size out of range");
  end

  localparam logic [19:0] ROM_BASE = 20'(32'h10000 - ROM_KB * 1024);        // [R2]
  localparam logic [19:0] RAM_TOP  = 20'(32'h400 + RAM_HALFKB * 512 - 1);   // [R6]

  typedef struct packed
  {
    mmd_pkg::mmd_sel_t    sel;
    mmd_pkg::mmd_region_t region;
    logic [7:0]           rdata;
  } mmd_state_t;

  mmd_state_t state;
  mmd_state_t next_state;

  function automatic mmd_pkg::mmd_region_t decode(input logic [19:0] a);
    // Vector table checked first: it lies inside the ROM span
    if (a >= mmd_pkg::VEC_BASE && a <= mmd_pkg::ROM_TOP)
      decode = mmd_pkg::MMD_VEC;                                            // [R3]
    else if (a >= ROM_BASE && a <= mmd_pkg::ROM_TOP)
      decode = mmd_pkg::MMD_ROM;                                            // [R2]
    else if (a >= mmd_pkg::FLASH_BASE && a <= mmd_pkg::FLASH_TOP)
      decode = mmd_pkg::MMD_FLASH;                                          // [R4]
    else if (a >= mmd_pkg::RAM_BASE && a <= RAM_TOP)
      decode = mmd_pkg::MMD_RAM;                                            // [R6] [R7]
    else if (a <= mmd_pkg::SFR0_TOP
             || (a >= mmd_pkg::SFR1_BASE && a <= mmd_pkg::SFR1_TOP))
      decode = mmd_pkg::MMD_SFR;                                            // [R8]
    else
      decode = mmd_pkg::MMD_RSVD;                                           // [R1] [R10]
  endfunction

  always_comb
  begin
    mmd_pkg::mmd_region_t r;
    r = decode(req_in.addr);
    next_state = state;
    next_state.sel.sfr       = 1'b0;
    next_state.sel.ram       = 1'b0;
    next_state.sel.flash     = 1'b0;
    next_state.sel.flash_blk = 4'h0;
    next_state.sel.rom       = 1'b0;
    next_state.sel.vec       = 1'b0;
    next_state.sel.wr        = 1'b0;
    if (req_in.req)
    begin
      next_state.region    = r;
      next_state.sel.addr  = req_in.addr;
      next_state.sel.wdata = req_in.wdata;
      // Reserved space: no select, so a write reaches nothing
      next_state.sel.wr    = req_in.wr && (r != mmd_pkg::MMD_RSVD);         // [R10]
      case (r)
        mmd_pkg::MMD_SFR:   next_state.sel.sfr = 1'b1;                      // [R9]
        mmd_pkg::MMD_RAM:   next_state.sel.ram = 1'b1;
        mmd_pkg::MMD_FLASH:
        begin
          next_state.sel.flash = 1'b1;
          next_state.sel.flash_blk =
            4'h1 << req_in.addr[mmd_pkg::FLASH_BLK_LSB +: 2];               // [R5]
        end
        mmd_pkg::MMD_ROM:   next_state.sel.rom = 1'b1;
        mmd_pkg::MMD_VEC:   next_state.sel.vec = 1'b1;
        default:            next_state.sel.wr  = 1'b0;
      endcase
    end
    // Read data follows the region of the previous access
    case (state.region)
      mmd_pkg::MMD_SFR:   next_state.rdata = rdata_sfr;
      mmd_pkg::MMD_RAM:   next_state.rdata = rdata_ram;
      mmd_pkg::MMD_FLASH: next_state.rdata = rdata_flash;
      mmd_pkg::MMD_ROM,
      mmd_pkg::MMD_VEC:   next_state.rdata = rdata_rom;
      default:            next_state.rdata = mmd_pkg::OPEN_READ;            // [R10]
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state        <= '0;
      state.region <= mmd_pkg::MMD_NONE;
      state.rdata  <= mmd_pkg::RESET_DATA;
    end
    else
      state <= next_state;
  end

  assign sel_out = state.sel;
  assign region  = state.region;
  assign rdata   = state.rdata;
endmodule

// *** mmd_decoder_assertions.sv ***
`timescale 1ns/100ps
module mmd_chk #(parameter int unsigned ROM_KB     = mmd_pkg::ROM_KB_DEF,
                 parameter int unsigned RAM_HALFKB = mmd_pkg::RAM_HALFKB_DEF) (
  input wire logic                 core_clk,  // Clock
  input wire logic                 reset_n,   // Reset
  input wire mmd_pkg::mmd_req_t    req_in,    // Access
  input wire logic [7:0]           rdata_ram, // RAM byte
  input wire mmd_pkg::mmd_sel_t    sel_out,   // Selects
  input wire mmd_pkg::mmd_region_t region,    // Region
  input wire logic [7:0]           rdata      // Read byte
);
  localparam logic [19:0] RL = 20'(20'h10000 - ROM_KB * 1024);
  localparam logic [19:0] RH = 20'(20'h00400 + RAM_HALFKB * 512 - 1);
  wire [19:0] a = req_in.addr;
  wire        q = req_in.req;
  // Exact one-hot match, so a second select firing is caught too
  wire [4:0]  s = {sel_out.sfr, sel_out.ram, sel_out.flash, sel_out.rom, sel_out.vec};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_vec_sel:
    assert property (q && a inside {[20'h0ffdc:20'h0ffff]} |=> s == 5'h01) else $error("vec");
  a_rom_sel:
    assert property (q && a inside {[RL:20'h0ffdb]} |=> s == 5'h02) else $error("rom");
  a_flash_blk:
    assert property (q && a[19:12] == 8'h03 |=> s == 5'h04
      && sel_out.flash_blk == 4'h1 << $past(a[11:10])) else $error("flash block");
  a_ram_sel:
    assert property (q && a inside {[20'h00400:RH]} |=> s == 5'h08) else $error("ram");
  a_sfr_sel:
    assert property (q && a inside {[20'h0:20'h002ff], [20'h02c00:20'h02fff]} |=> s == 5'h10)
      else $error("sfr");
  a_rsvd_read:
    assert property (q && !(a inside {[20'h0:20'h002ff], [20'h00400:RH], [20'h02c00:20'h03fff],
      [RL:20'h0ffff]}) |=> s == 5'h0 && !sel_out.wr ##1 rdata == 8'hff) else $error("reserved");
  a_ram_data:
    assert property (sel_out.ram |=> rdata == $past(rdata_ram)) else $error("ram data");
  a_addr_pass:
    assert property (q |=> sel_out.addr == $past(a) && region != mmd_pkg::MMD_NONE)
      else $error("address");
  cover property (sel_out.vec);
  cover property (sel_out.flash_blk == 4'h8);
  cover property (region == mmd_pkg::MMD_RSVD && sel_out.addr[19:16] != 4'h0);
endmodule
bind mmd_decoder mmd_chk #(.ROM_KB(ROM_KB), .RAM_HALFKB(RAM_HALFKB)) u_chk (.core_clk, .reset_n,
  .req_in, .rdata_ram, .sel_out, .region, .rdata);

// *** mmd_mem.sv ***
`timescale 1ns/100ps
module mmd_mem (
  input  wire mmd_pkg::mmd_sel_t sel_out, // Selects from decoder
  output logic [31:0]            rd       // Bytes: rom, flash, ram, sfr
);
  wire [7:0] b = sel_out.addr[7:0];
  // Unselected bytes show the inverse, so a stale value never matches
  assign rd = {b ^ (sel_out.rom ? 8'h10 : sel_out.vec ? 8'h20 : 8'hef),
               b ^ (sel_out.flash ? 8'h08 : 8'hf7),
               b ^ (sel_out.ram ? 8'h04 : 8'hfb),
               b ^ (sel_out.sfr ? 8'h02 : 8'hfd)};
endmodule

// *** memory_map_address_decoder_test.sv ***
`timescale 1ns/100ps
module memory_map_address_decoder_test;
  logic                 core_clk = 1'b0, reset_n = 1'b0;
  mmd_pkg::mmd_req_t    req_in = '0;
  logic [31:0]          rd;
  logic [7:0]           rdata;
  mmd_pkg::mmd_sel_t    sel_out;
  mmd_pkg::mmd_region_t region;
  int                   fail_count = 0, n_checks = 0;
  always #12.5 core_clk = ~core_clk;
  mmd_decoder DUT (.core_clk, .reset_n, .req_in, .rdata_sfr(rd[7:0]), .rdata_ram(rd[15:8]),
    .rdata_flash(rd[23:16]), .rdata_rom(rd[31:24]), .sel_out, .region, .rdata);
  mmd_mem u_mem (.sel_out, .rd);
  task automatic chk(input logic [19:0] got, exp);
    n_checks++;
    if (got !== exp) $display("CHECK FAILED %0t %h %h", $time, got, exp);
    if (got !== exp) fail_count++;
  endtask
  task automatic pr(input logic [19:0] a, input logic [6:0] r, input logic wr);
    @(negedge core_clk);
    req_in = '{1'b1, wr, a, 8'h5a};
    @(negedge core_clk);
    req_in.req = 1'b0;
    chk({region, sel_out.flash_blk, sel_out.wr}, {r, r[3] ? 4'h1 << a[11:10] : 4'h0, wr & !r[6]});
    chk(sel_out.addr, a);
    chk(20'(sel_out.wdata), 20'h0005a);
    @(negedge core_clk);
    chk(20'(rdata), r[6] ? 20'hff : 20'(a[7:0] ^ 8'(r)));
  endtask
  task automatic t_top;
    pr(20'h07fff, mmd_pkg::MMD_RSVD, 1'b0);
    pr(20'h08000, mmd_pkg::MMD_ROM, 1'b0);
    pr(20'h0ffdb, mmd_pkg::MMD_ROM, 1'b1);
    pr(20'h0ffdc, mmd_pkg::MMD_VEC, 1'b0);
    pr(20'h10000, mmd_pkg::MMD_RSVD, 1'b1);
  endtask
  task automatic t_flash;
    for (int b = 0; b < 4; b++)
      pr(20'h03000 + 20'(b) * 20'h555, mmd_pkg::MMD_FLASH, b[0]);
  endtask
  task automatic t_low;
    pr(20'h00400, mmd_pkg::MMD_RAM, 1'b1);
    pr(20'h00dff, mmd_pkg::MMD_RAM, 1'b0);
    pr(20'h00e00, mmd_pkg::MMD_RSVD, 1'b1);
    pr(20'h002ff, mmd_pkg::MMD_SFR, 1'b0);
    pr(20'h00300, mmd_pkg::MMD_RSVD, 1'b0);
    pr(20'h02c00, mmd_pkg::MMD_SFR, 1'b1);
  endtask
  task automatic summarize(input int late);
    fail_count += late;
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    chk(20'(region), 20'(mmd_pkg::MMD_NONE));
    chk(20'(rdata), 20'(mmd_pkg::RESET_DATA));
    t_top;
    t_flash;
    t_low;
    summarize(0);
  end
  initial #20us summarize(1);
endmodule
